// ===== core/smbus_target_port.sv
// SMBus target end: indexed block write/read into the byte-wide config map.
// Assumes scl/sda come from another domain; straps are static pins.
`timescale 1ns/10ps
`default_nettype none
`include "smbus_cfg.svh"

module smbus_target_port #(
   parameter logic [6:0] ADDR_SEL_LO  = 7'h20,
   parameter logic [6:0] ADDR_SEL_MID = 7'h21,
   parameter logic [6:0] ADDR_SEL_HI  = 7'h22
) (
   // System
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Link
   smbus_link_if.target    link,
   // Straps: address 00 low, 01 mid, 1x high; loop mode strap used as the mode value as is
   input  wire logic [1:0] target_addr_strap,
   input  wire logic [1:0] loop_mode_strap,
   // Configuration outputs
   output logic [3:0]      output_gate,
   output logic [1:0]      disable_state_field,
   output logic [1:0]      loop_mode,
   output logic [1:0]      amplitude,
   output logic [3:0]      output_edge_rate,
   output logic            feedback_edge_rate,
   output logic [1:0]      frequency_choice,
   output logic            freq_change_en
);
   smbus_pkg::dev_state_t st_q;
   smbus_pkg::role_t      role_q;

   logic       scl_s1_q, scl_s2_q, scl_s3_q;
   logic       sda_s1_q, sda_s2_q, sda_s3_q;
   logic [1:0] adr_s1_q, adr_s2_q, mode_s1_q, mode_s2_q;
   logic [1:0] latch_cnt_q;
   logic [6:0] tgt_addr_q;
   logic [1:0] mode_rb_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] idx_q;
   logic       rd_q;
   logic       nack_q;
   logic       sda_oe_q;
   // Configuration bits
   logic [3:0] gate_q;
   logic       mode_sel_q;
   logic [1:0] mode_sw_q;
   logic [1:0] amp_q;
   logic [3:0] edge_q;
   logic       fsel_en_q;
   logic [1:0] fsel_q;
   logic       fb_edge_q;
   logic [4:0] len_q;
   logic [1:0] stop_q;
   logic [1:0] loop_mode_q;
   logic [1:0] freq_q;

   function automatic logic [7:0] read_map(input logic [7:0] i);
      case (i)
         `REG_OE:   read_map = {1'b0, gate_q[3], 1'b0, gate_q[2], gate_q[1], 1'b0,
                                gate_q[0], 1'b0};
         `REG_MODE: read_map = {mode_rb_q, mode_sel_q, mode_sw_q, 1'b0, amp_q}
                               | `RSV_ONE_B1;
         `REG_EDGE: read_map = {1'b0, edge_q[3], 1'b0, edge_q[2], edge_q[1], 1'b0,
                                edge_q[0], 1'b0} | `RSV_ONE_B2;
         `REG_FREQ: read_map = {2'h0, fsel_en_q, fsel_q, 2'h0, fb_edge_q} | `RSV_ONE_B3;
         `REG_LEN:  read_map = {3'h0, len_q};
         `REG_STOP: read_map = {6'h00, stop_q};
         default:   read_map = 8'h00;
      endcase
   endfunction

   // Link edge and condition detection on the second and third stages
   wire scl_rise  = scl_s2_q & ~scl_s3_q;
   wire scl_fall  = ~scl_s2_q & scl_s3_q;
   wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   wire stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   wire byte_end  = (st_q == smbus_pkg::d_rx) && scl_fall && (cnt_q == 4'h8);
   wire addr_hit  = (sh_q[7:1] == tgt_addr_q);
   wire wr_stb    = byte_end && (role_q == smbus_pkg::r_data);
   wire [7:0] rd_idx  = (role_q == smbus_pkg::r_data) ? idx_q + 8'h01 : idx_q;
   wire [7:0] rd_byte = read_map(rd_idx);
   wire [7:0] len_byte = {3'h0, len_q};
   wire [6:0] strap_addr = target_addr_strap_sel(adr_s2_q);

   function automatic logic [6:0] target_addr_strap_sel(input logic [1:0] s);
      case (s)
         2'h0:    target_addr_strap_sel = ADDR_SEL_LO;
         2'h1:    target_addr_strap_sel = ADDR_SEL_MID;
         default: target_addr_strap_sel = ADDR_SEL_HI;
      endcase
   endfunction

   // Synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
         {adr_s1_q, adr_s2_q, mode_s1_q, mode_s2_q} <= 8'h00;
      end else begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= {link.scl, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_s3_q} <= {link.sda, sda_s1_q, sda_s2_q};
         {adr_s1_q, adr_s2_q} <= {target_addr_strap, adr_s1_q};
         {mode_s1_q, mode_s2_q} <= {loop_mode_strap, mode_s1_q};
      end
   end

   // Straps caught once the synchronisers have filled after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_cnt_q <= 2'h0;
         tgt_addr_q  <= ADDR_SEL_LO;
         mode_rb_q   <= 2'h0;
      end else if (latch_cnt_q != 2'h3) begin
         latch_cnt_q <= latch_cnt_q + 2'h1;
         if (latch_cnt_q == 2'h2) begin
            tgt_addr_q <= strap_addr;
            mode_rb_q  <= mode_s2_q;
         end
      end
   end

   // Bus protocol engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= smbus_pkg::d_idle;
         role_q   <= smbus_pkg::r_addr;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         idx_q    <= 8'h00;
         rd_q     <= 1'b0;
         nack_q   <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         st_q     <= smbus_pkg::d_idle;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         st_q     <= smbus_pkg::d_rx;
         role_q   <= smbus_pkg::r_addr;
         cnt_q    <= 4'h0;
         sda_oe_q <= 1'b0;
      end else begin
         case (st_q)
            smbus_pkg::d_rx: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_s2_q};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_end) begin
                  if (role_q == smbus_pkg::r_addr && !addr_hit) begin
                     st_q <= smbus_pkg::d_idle;
                  end else begin
                     st_q     <= smbus_pkg::d_rx_ack;
                     sda_oe_q <= 1'b1;
                  end
                  if (role_q == smbus_pkg::r_addr) begin
                     rd_q <= sh_q[0];
                  end
                  if (role_q == smbus_pkg::r_index) begin
                     idx_q <= sh_q;
                  end
               end
            end
            smbus_pkg::d_rx_ack: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (role_q == smbus_pkg::r_addr && rd_q) begin
                     st_q     <= smbus_pkg::d_tx;
                     role_q   <= smbus_pkg::r_count;
                     sh_q     <= len_byte;
                     sda_oe_q <= ~len_byte[7];
                  end else begin
                     st_q     <= smbus_pkg::d_rx;
                     sda_oe_q <= 1'b0;
                     case (role_q)
                        smbus_pkg::r_addr:  role_q <= smbus_pkg::r_index;
                        smbus_pkg::r_index: role_q <= smbus_pkg::r_count;
                        default:            role_q <= smbus_pkg::r_data;
                     endcase
                     if (role_q == smbus_pkg::r_data) begin
                        idx_q <= idx_q + 8'h01;
                     end
                  end
               end
            end
            smbus_pkg::d_tx: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h7) begin
                     st_q     <= smbus_pkg::d_tx_ack;
                     sda_oe_q <= 1'b0;
                  end else begin
                     cnt_q    <= cnt_q + 4'h1;
                     sh_q     <= {sh_q[6:0], 1'b0};
                     sda_oe_q <= ~sh_q[6];
                  end
               end
            end
            smbus_pkg::d_tx_ack: begin
               if (scl_rise) begin
                  nack_q <= sda_s2_q;
               end else if (scl_fall) begin
                  if (nack_q) begin
                     st_q <= smbus_pkg::d_idle;
                  end else begin
                     st_q     <= smbus_pkg::d_tx;
                     cnt_q    <= 4'h0;
                     sh_q     <= rd_byte;
                     sda_oe_q <= ~rd_byte[7];
                     role_q   <= smbus_pkg::r_data;
                     idx_q    <= rd_idx;
                  end
               end
            end
            default: st_q <= smbus_pkg::d_idle;
         endcase
      end
   end

   // Configuration registers; reserved positions are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_q     <= `RST_OE;
         mode_sel_q <= 1'b0;
         mode_sw_q  <= 2'h0;
         amp_q      <= `RST_AMP;
         edge_q     <= `RST_EDGE;
         fsel_en_q  <= 1'b0;
         fsel_q     <= 2'h0;
         fb_edge_q  <= 1'b1;
         len_q      <= `RST_LEN;
         stop_q     <= `RST_STOP;
      end else if (wr_stb) begin
         case (idx_q)
            `REG_OE:   gate_q <= {sh_q[6], sh_q[4], sh_q[3], sh_q[1]};
            `REG_MODE: {mode_sel_q, mode_sw_q, amp_q} <= {sh_q[5:3], sh_q[1:0]};
            `REG_EDGE: edge_q <= {sh_q[6], sh_q[4], sh_q[3], sh_q[1]};
            `REG_FREQ: {fsel_en_q, fsel_q, fb_edge_q} <= {sh_q[5:3], sh_q[0]};
            `REG_LEN:  len_q <= sh_q[4:0];
            `REG_STOP: stop_q <= sh_q[1:0];
            default: ;
         endcase
      end
   end

   // Effective operating selections
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_mode_q <= 2'h0;
         freq_q      <= 2'h0;
      end else begin
         loop_mode_q <= mode_sel_q ? mode_sw_q : mode_rb_q;
         freq_q      <= fsel_en_q ? fsel_q : 2'h0;
      end
   end

   assign link.dev_sda_o       = 1'b0;
   assign link.dev_sda_oe      = sda_oe_q;
   assign output_gate          = gate_q;
   assign disable_state_field  = stop_q;
   assign loop_mode            = loop_mode_q;
   assign amplitude            = amp_q;
   assign output_edge_rate     = edge_q;
   assign feedback_edge_rate   = fb_edge_q;
   assign frequency_choice     = freq_q;
   assign freq_change_en       = fsel_en_q;
endmodule
`default_nettype wire

// ===== core/smbus_cfg.svh
// Register offsets, field defaults and timing counts for the SMBus config port.
// Assumes a 25 MHz pclk; included by both ends of the link.
`ifndef SMBUS_CFG_SVH
`define SMBUS_CFG_SVH

// Target register map (byte index)
`define REG_OE       8'h00
`define REG_MODE     8'h01
`define REG_EDGE     8'h02
`define REG_FREQ     8'h03
`define REG_LEN      8'h07
`define REG_STOP     8'h0b

// Reset values
`define RST_OE       4'hf
`define RST_AMP      2'h2
`define RST_EDGE     4'hf
`define RST_LEN      5'h08
`define RST_STOP     2'h0

// Reserved bits that read as one
`define RSV_ONE_B1   8'h04
`define RSV_ONE_B2   8'h85
`define RSV_ONE_B3   8'hc0

// Timing
`define PCLK_KHZ     25000
`define SCL_KHZ      100
`define SCL_QTR      ((`PCLK_KHZ) / ((`SCL_KHZ) * 4))

// Controller register map (byte address)
`define H_CTRL       8'h00
`define H_STAT       8'h04
`define H_DATA       8'h20

`endif

// ===== core/smbus_pkg.sv
// Types shared by the SMBus target and controller.
// Assumes nothing beyond a SystemVerilog compiler.
package smbus_pkg;
   typedef enum logic [2:0] {d_idle, d_rx, d_rx_ack, d_tx, d_tx_ack} dev_state_t;
   typedef enum logic [1:0] {r_addr, r_index, r_count, r_data} role_t;
   typedef enum logic [1:0] {h_idle, h_start, h_byte, h_stop} host_state_t;
endpackage

// ===== core/smbus_link_if.sv
// SMBus wires between controller and target; resolves the open-drain lines.
// Assumes each end drives only the enables; an enable high pulls the line low.
`timescale 1ns/10ps
`default_nettype none
interface smbus_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport controller (input sda, output host_scl_o, output host_scl_oe,
                       output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ===== core/smbus_block_controller.sv
// SMBus controller end: runs indexed block writes and reads ordered over APB.
// Assumes APB on pclk; the target may answer on sda only.
`timescale 1ns/10ps
`default_nettype none
`include "smbus_cfg.svh"

module smbus_block_controller #(
   parameter int BUF_DEPTH = 8
) (
   // System
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   smbus_link_if.controller link
);
   localparam int AW = $clog2(BUF_DEPTH);
   localparam logic [9:0] QTR = 10'(`SCL_QTR);

   smbus_pkg::host_state_t st_q;
   logic [7:0]  buf_q [BUF_DEPTH];
   logic [6:0]  addr_q;
   logic [7:0]  index_q;
   logic [4:0]  count_q;
   logic        rd_q, busy_q, err_q;
   logic [7:0]  rxcnt_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic        sda_s1_q, sda_s2_q;
   logic [9:0]  div_q;
   logic [1:0]  q_q;
   logic [3:0]  bit_q;
   logic [5:0]  nbyte_q;
   logic [7:0]  sh_q;
   logic        ack_q, scl_oe_q, sda_oe_q;

   wire setup    = psel & ~penable;
   wire wr_acc   = psel & penable & pready_q & pwrite;
   wire is_ctrl  = paddr == `H_CTRL;
   wire is_stat  = paddr == `H_STAT;
   wire is_data  = paddr[7:5] == `H_DATA >> 5 && paddr[4:2] < BUF_DEPTH;
   wire [AW-1:0] aidx = paddr[2 +: AW];
   wire go       = wr_acc & is_ctrl & pwdata[0] & ~busy_q;
   wire tick     = div_q == QTR - 10'h001;
   wire [5:0] total = {1'b0, count_q} + (rd_q ? 6'h04 : 6'h03);
   wire is_rx    = rd_q && nbyte_q >= 6'h03 && nbyte_q != 6'h02;
   wire last     = nbyte_q == total - 6'h01;
   wire [AW-1:0] tx_i = AW'(nbyte_q - 6'h03);
   wire [AW-1:0] rx_i = AW'(nbyte_q - 6'h04);
   wire [7:0] tx_byte = nbyte_q == 6'h00 ? {addr_q, 1'b0} :
                        nbyte_q == 6'h01 ? index_q :
                        nbyte_q == 6'h02 ? (rd_q ? {addr_q, 1'b1} : {3'h0, count_q}) :
                        buf_q[tx_i];
   wire [31:0] rd_data = is_ctrl ? {1'b0, addr_q, 3'h0, count_q, index_q, 6'h00, rd_q, 1'b0} :
                         is_stat ? {16'h0000, rxcnt_q, 6'h00, err_q, busy_q} :
                         is_data ? {24'h000000, buf_q[aidx]} : 32'h00000000;

   // APB: answer in the access cycle right after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~(is_ctrl | is_stat | is_data);
         if (setup) begin
            prdata_q <= rd_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {addr_q, index_q, count_q, rd_q} <= 21'h000000;
         {sda_s1_q, sda_s2_q} <= 2'h3;
         div_q <= 10'h000;
      end else begin
         {sda_s1_q, sda_s2_q} <= {link.sda, sda_s1_q};
         div_q <= (tick || go) ? 10'h000 : div_q + 10'h001;
         if (wr_acc && is_ctrl && !busy_q) begin
            {addr_q, count_q, index_q, rd_q} <= {pwdata[30:24], pwdata[20:16],
                                                 pwdata[15:8], pwdata[1]};
         end
      end
   end

   // Buffer: APB fills it when idle, the engine fills it on reads
   always_ff @(posedge pclk) begin
      if (wr_acc && is_data && !busy_q) begin
         buf_q[aidx] <= pwdata[7:0];
      end else if (st_q == smbus_pkg::h_byte && tick && q_q == 2'h3 && bit_q == 4'h8
                   && is_rx && nbyte_q != 6'h03) begin
         buf_q[rx_i] <= sh_q;
      end
   end

   // Bit engine: four quarter phases per SCL period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= smbus_pkg::h_idle;
         {busy_q, err_q, ack_q, scl_oe_q, sda_oe_q} <= 5'h00;
         {q_q, bit_q, nbyte_q, sh_q, rxcnt_q} <= 28'h0000000;
      end else if (go) begin
         st_q    <= smbus_pkg::h_start;
         busy_q  <= 1'b1;
         err_q   <= 1'b0;
         q_q     <= 2'h0;
         nbyte_q <= 6'h00;
      end else if (tick && st_q != smbus_pkg::h_idle) begin
         q_q <= q_q + 2'h1;
         case (st_q)
            smbus_pkg::h_start: begin
               case (q_q)
                  2'h0:    sda_oe_q <= 1'b0;
                  2'h1:    scl_oe_q <= 1'b0;
                  2'h2:    sda_oe_q <= 1'b1;
                  default: begin
                     scl_oe_q <= 1'b1;
                     st_q     <= smbus_pkg::h_byte;
                     bit_q    <= 4'h0;
                  end
               endcase
            end
            smbus_pkg::h_byte: begin
               case (q_q)
                  2'h0: begin
                     if (bit_q == 4'h8) begin
                        sda_oe_q <= is_rx & ~last;
                     end else if (bit_q == 4'h0 && !is_rx) begin
                        sh_q     <= tx_byte;
                        sda_oe_q <= ~tx_byte[7];
                     end else begin
                        sda_oe_q <= ~is_rx & ~sh_q[7];
                     end
                  end
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: begin
                     if (bit_q == 4'h8) begin
                        ack_q <= ~sda_s2_q;
                     end else begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                     end
                  end
                  default: begin
                     scl_oe_q <= 1'b1;
                     bit_q    <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (is_rx && nbyte_q == 6'h03) begin
                           rxcnt_q <= sh_q;
                        end
                        if (!is_rx && !ack_q) begin
                           err_q <= 1'b1;
                           st_q  <= smbus_pkg::h_stop;
                        end else if (last) begin
                           st_q <= smbus_pkg::h_stop;
                        end else begin
                           nbyte_q <= nbyte_q + 6'h01;
                           if (rd_q && nbyte_q == 6'h01) begin
                              st_q <= smbus_pkg::h_start;
                           end
                        end
                     end
                  end
               endcase
            end
            smbus_pkg::h_stop: begin
               case (q_q)
                  2'h0:    sda_oe_q <= 1'b1;
                  2'h1:    scl_oe_q <= 1'b0;
                  2'h2:    sda_oe_q <= 1'b0;
                  default: begin
                     st_q   <= smbus_pkg::h_idle;
                     busy_q <= 1'b0;
                  end
               endcase
            end
            default: st_q <= smbus_pkg::h_idle;
         endcase
      end
   end

   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign link.host_scl_o  = 1'b0;
   assign link.host_scl_oe = scl_oe_q;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ===== bench/smbus_link_chk.sv
// Checker for the wires between controller and target.
// Assumes a 25 MHz pclk and the link interface signals as inputs.
`timescale 1ns/10ps
`default_nettype none
module smbus_link_chk (
   // System
   input wire logic pclk,
   input wire logic presetn,
   // Link
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic [11:0] hi_q;
   logic [11:0] hi_d;
   logic [11:0] lo_q;
   logic [11:0] lo_d;
   logic [11:0] dv_q;
   logic [11:0] dv_d;
   logic        idle_q;
   logic        idle_d;
   logic        sda_q;
   // Saturating run lengths of scl released, scl pulled, target pulling
   assign hi_d = host_scl_oe ? 12'h000 : hi_q + 12'(~&hi_q);
   assign lo_d = host_scl_oe ? lo_q + 12'(~&lo_q) : 12'h000;
   assign dv_d = dev_sda_oe ? dv_q + 12'(~&dv_q) : 12'h000;
   // Set by reset or a stop: the scl high time up to the next start is idle time
   assign idle_d = host_scl_oe ? 1'b0 : (idle_q | (scl & sda & ~sda_q));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_q   <= 12'h000;
         lo_q   <= 12'h000;
         dv_q   <= 12'h000;
         idle_q <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         hi_q   <= hi_d;
         lo_q   <= lo_d;
         dv_q   <= dv_d;
         idle_q <= idle_d;
         sda_q  <= sda;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   reset_idle_a: assert property ($rose(presetn) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
      else $error("link not idle after reset");
   start_host_a: assert property (scl && $fell(sda) |-> host_sda_oe)
      else $error("start not made by controller");
   dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
      else $error("target changed sda near scl high");
   no_clash_a: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
      else $error("both ends pull sda while scl high");
   dev_pull_bound_a: assert property (dv_q < 12'h8fc)
      else $error("target holds sda too long");
   scl_high_a: assert property ($rose(host_scl_oe) && !idle_q |-> hi_q inside {[12'h076:12'h082]})
      else $error("scl high time wrong");
   scl_low_a: assert property ($fell(host_scl_oe) |-> lo_q inside {[12'h076:12'h082]})
      else $error("scl low time wrong");
   stop_quiet_a: assert property (scl && $rose(sda) |-> !dev_sda_oe [*8])
      else $error("target drives after stop");
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench: controller and target joined over the link.
// Assumes the core files compile first; all traffic is ordered over APB.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  gate, edges;
   logic [1:0]  dstate, lmode, amp, fsel, addr_strap, mode_strap;
   logic        fb, fen;
   int          fails, total_checks;
   smbus_link_if link ();
   smbus_target_port smbus_target_port_inst (.pclk(pclk), .presetn(presetn), .link(link),
      .target_addr_strap(addr_strap), .loop_mode_strap(mode_strap), .output_gate(gate),
      .disable_state_field(dstate), .loop_mode(lmode), .amplitude(amp),
      .output_edge_rate(edges), .feedback_edge_rate(fb), .frequency_choice(fsel),
      .freq_change_en(fen));
   smbus_block_controller smbus_block_controller_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   smbus_link_chk smbus_link_chk_inst (.pclk(pclk), .presetn(presetn),
      .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
      .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Start a transfer and poll until the controller is no longer busy
   task automatic xfer(input logic rdn, input logic [7:0] idx, input logic [4:0] x,
                       input logic [6:0] adr);
      apb(1'b1, 8'h00, {1'b0, adr, 3'h0, x, idx, 6'h00, rdn, 1'b1});
      do begin
         repeat (40) @(posedge pclk);
         apb(1'b0, 8'h04, 32'h0);
      end while (rd[0] !== 1'b0);
   endtask
   task automatic put4(input logic [31:0] w);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'h20 + 8'(4 * i), {24'h0, w[31 - 8 * i -: 8]});
   endtask
   task automatic get4(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
         chk("read byte", {24'h0, w[31 - 8 * i -: 8]}, rd);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      fails++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {addr_strap, mode_strap} = 4'h6;
      fails = 0;
      total_checks = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("gates", 32'h3c, {26'h0, gate, dstate});
      chk("loop mode", 32'h2, {30'h0, lmode});
      chk("freq", 32'h0, {29'h0, fen, fsel});
      chk("edges", 32'h1f, {27'h0, edges, fb});
      chk("amplitude", 32'h2, {30'h0, amp});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      xfer(1'b1, 8'h00, 5'h4, 7'h21);
      apb(1'b0, 8'h04, 32'h0);
      chk("count", 32'h0800, rd & 32'hff03);
      get4(32'h5a86dfc1);
      put4(32'h18001800);
      xfer(1'b0, 8'h01, 5'h3, 7'h21);
      chk("sw mode off", 32'h2, {30'h0, lmode});
      chk("freq off", 32'h0, {29'h0, fen, fsel});
      chk("edges set", 32'h0, {27'h0, edges, fb});
      put4(32'h00ff00ff);
      xfer(1'b0, 8'h00, 5'h4, 7'h21);
      chk("gates off", 32'h0, {28'h0, gate});
      chk("sw mode on", 32'h3, {30'h0, lmode});
      chk("freq on", 32'h7, {29'h0, fen, fsel});
      chk("amp set", 32'h3, {30'h0, amp});
      xfer(1'b1, 8'h00, 5'h4, 7'h21);
      get4(32'h00bf85f9);
      xfer(1'b0, 8'h00, 5'h1, 7'h20);
      apb(1'b0, 8'h04, 32'h0);
      chk("no ack", 32'h2, rd & 32'h3);
      // Second reset with other straps: address and mode readback follow them
      presetn <= 1'b0;
      {addr_strap, mode_strap} <= 4'h1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("strap mode", 32'h1, {30'h0, lmode});
      chk("gates reset", 32'hf, {28'h0, gate});
      apb(1'b1, 8'h20, 32'h0);
      xfer(1'b0, 8'h00, 5'h1, 7'h20);
      apb(1'b0, 8'h04, 32'h0);
      chk("strap ack", 32'h0, rd & 32'h3);
      chk("strap write", 32'h0, {28'h0, gate});
      end_of_test();
   end
endmodule
`default_nettype wire
